/* tb/pmscan_far_model.sv */
/* Behavioural flash and CRC engine facing the scanner.
   Flash answers one cycle after a request; words are counted and folded. */
`timescale 1ns/1ps
module pmscan_far_model #(
    parameter int LIMIT = 32'h0000_0300
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [21:0] nvm_addr,
    input  wire logic        nvm_req,
    output logic      [15:0] nvm_rdata,
    output logic             nvm_unimpl,
    input  wire logic        stall,
    output logic             crc_ready,
    input  wire logic [15:0] crc_data,
    input  wire logic        crc_data_valid,
    input  wire logic        crc_reset,
    output logic      [15:0] word_count,
    output logic      [15:0] word_fold
);
    // Memory ends at LIMIT; CRC refuses words while held in reset or stalled
    assign nvm_unimpl = (nvm_addr >= 22'(LIMIT));
    assign crc_ready  = !stall && !crc_reset;
    // Released data lines flip every cycle so stale data is never mistaken for good
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_rdata  <= 16'h0;
            word_count <= 16'h0;
            word_fold  <= 16'h0;
        end else begin
            nvm_rdata <= nvm_req ? (nvm_addr[15:0] ^ 16'h5a5a) : ~nvm_rdata;
            if (crc_data_valid) begin
                word_count <= word_count + 16'h1;
                word_fold  <= word_fold ^ crc_data;
            end
        end
    end
endmodule

/* tb/pmscan_properties.sv */
/* Checker of the scanner's port timing: bus answer, word handshake, flag clearing.
   Sees only top module ports; bound from the testbench top file. */
`timescale 1ns/1ps
module pmscan_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        nvm_req,
    input wire logic        crc_ready,
    input wire logic        crc_data_valid,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus setup phase and flash read request
    sequence s_setup; psel && !penable; endsequence
    sequence s_req; nvm_req; endsequence
    // Zero-wait answer, only inside the access phase
    AST_PREADY_AFTER_SETUP: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_PREADY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    AST_UNMAPPED_ERR: assert property ((s_setup ##0 paddr >= 8'h20) |=> pslverr)
        else $error("unmapped offset not refused");
    // A request or a word only follows a ready CRC
    AST_REQ_NEEDS_READY: assert property (nvm_req |-> $past(crc_ready))
        else $error("flash read without CRC ready");
    AST_WORD_NEEDS_READY: assert property (crc_data_valid |-> $past(crc_ready))
        else $error("word offered without CRC ready");
    // Data needs two cycles from request to the CRC input
    AST_REQ_GAP: assert property (s_req |=> (!nvm_req && !crc_data_valid) ##1 !nvm_req)
        else $error("word pipeline too short");
    // Only software clears the flag, so irq falls only after a bus write
    AST_IRQ_SW_CLEAR: assert property ($fell(irq) |->
        ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)))
        else $error("irq fell without a write");
endmodule

/* tb/tb_pmscan.sv */
/* Testbench for the scanner: register table, scans in every mode, abort, stop, disable.
   Assumes the far-side model and the checker bound below. */
`timescale 1ns/1ps
module tb_pmscan;
    import pmscan_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} pms_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_req, nvm_unimpl;
    logic cpu_nvm_busy, cpu_stall, crc_ready, crc_data_valid, crc_reset, irq, crc_stall;
    logic busy_q, peek_on, er;
    logic [7:0] paddr, trig_in, cyc;
    logic [31:0] pwdata, prdata, rd;
    logic [21:0] nvm_addr;
    logic [15:0] nvm_rdata, crc_data, word_count, word_fold, c_snap;
    int bad_count, compares, stall_cnt;
    pms_row_t rows [8] = '{'{1'b0, PMS_OFF_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, PMS_OFF_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b1, PMS_OFF_TRIG, 32'h5, 32'h5, 1'b0},
        '{1'b1, PMS_OFF_MASK, 32'h1, 32'h1, 1'b0}, '{1'b1, PMS_OFF_START, 32'h123, 32'h123, 1'b0},
        '{1'b1, PMS_OFF_END, 32'h456, 32'h456, 1'b0}, '{1'b1, PMS_OFF_CTRL, 32'hc0, 32'hc0, 1'b0},
        '{1'b1, 8'h20, 32'hff, 32'h0, 1'b1}};

    pmscan i_pmscan (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .nvm_addr(nvm_addr), .nvm_req(nvm_req), .nvm_rdata(nvm_rdata),
        .nvm_unimpl(nvm_unimpl), .cpu_nvm_busy(cpu_nvm_busy), .cpu_stall(cpu_stall),
        .crc_ready(crc_ready), .crc_data(crc_data), .crc_data_valid(crc_data_valid),
        .crc_reset(crc_reset), .trig_in(trig_in), .irq(irq));
    pmscan_far_model i_pmscan_far_model (.pclk(pclk), .presetn(presetn), .nvm_addr(nvm_addr),
        .nvm_req(nvm_req), .nvm_rdata(nvm_rdata), .nvm_unimpl(nvm_unimpl), .stall(crc_stall),
        .crc_ready(crc_ready), .crc_data(crc_data), .crc_data_valid(crc_data_valid),
        .crc_reset(crc_reset), .word_count(word_count), .word_fold(word_fold));

    always #50 pclk = ~pclk;
    // Processor flash demand and CRC stalls follow a fixed pattern
    always @(posedge pclk) begin
        cyc <= cyc + 8'h1;
        cpu_nvm_busy <= cyc[0] ^ cyc[2];
        crc_stall <= (cyc[2:0] == 3'h5);
        busy_q <= cpu_nvm_busy;
        if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
        if (peek_on && nvm_req === 1'b1) check(32'(busy_q), 32'h0);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        check(32'(pready), 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic apb_rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Full scan of n words in mode m; the flash word is its address xor a pattern
    task automatic scan(input logic [1:0] m, input logic [31:0] s, input logic [31:0] e, input int n);
        logic [15:0] c0, f0, fe;
        int i, t0, w;
        c0 = word_count;
        f0 = word_fold;
        fe = 16'h0;
        w = 0;
        for (i = 0; i < n; i++) fe = fe ^ (s[15:0] + 16'(i)) ^ 16'h5a5a;
        apb(1'b1, PMS_OFF_START, s);
        apb(1'b1, PMS_OFF_END, e);
        apb(1'b1, PMS_OFF_CRC, 32'h3);
        apb(1'b1, PMS_OFF_CTRL, 32'h1 | (32'(m) << 4));
        peek_on = (m == PMS_MODE_PEEK);
        t0 = stall_cnt;
        apb(1'b1, PMS_OFF_CTRL, 32'h3 | (32'(m) << 4));
        if (m == PMS_MODE_TRIG) begin
            repeat (8) @(posedge pclk);
            check(32'(word_count - c0), 32'h0);
            trig_in <= 8'h20;
            repeat (2) @(posedge pclk);
            trig_in <= 8'h00;
        end
        if (m == PMS_MODE_BURST) begin
            @(posedge pclk);
            check(32'(cpu_stall), 32'h1);
            apb(1'b1, PMS_OFF_CTRL, 32'h1 | (32'(m) << 4));
        end
        while (irq !== 1'b1 && w < 3000) begin
            @(posedge pclk);
            w++;
        end
        check(32'(irq), 32'h1);
        peek_on = 1'b0;
        check(32'(word_count - c0), 32'(n));
        check(32'(word_fold ^ f0), 32'(fe));
        if (m == PMS_MODE_PEEK) check(32'(stall_cnt - t0), 32'h0);
        if (!m[0]) check(32'(stall_cnt - t0 < w), 32'h1);
        apb_rd(PMS_OFF_CTRL, 32'h1 | (32'(m) << 4));
        apb_rd(PMS_OFF_STATUS, 32'h1);
        apb(1'b1, PMS_OFF_STATUS, 32'h1);
        apb_rd(PMS_OFF_STATUS, 32'h0);
        check(32'(irq), 32'h0);
    endtask

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog: far beyond the expected few hundred cycles
    initial begin
        #3000000;
        bad_count++;
        end_sim();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, trig_in, cyc} = '0;
        {cpu_nvm_busy, crc_stall, busy_q, peek_on, stall_cnt, bad_count, compares} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(crc_reset), 32'h1);
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb_rd(rows[i].a, rows[i].e);
            check(32'(er), 32'(rows[i].er));
        end
        for (int k = 0; k < 4; k++) scan(2'(k), 32'h100 + 32'(k * 16), 32'h107 + 32'(k * 16), 8);
        scan(PMS_MODE_CONC, 32'h2fd, 32'h305, 4);
        apb(1'b1, PMS_OFF_CRC, 32'h1);
        apb(1'b1, PMS_OFF_CTRL, 32'h3);
        apb_rd(PMS_OFF_CTRL, 32'h1);
        apb(1'b1, PMS_OFF_START, 32'h10);
        apb(1'b1, PMS_OFF_END, 32'h1ff);
        apb(1'b1, PMS_OFF_CRC, 32'h3);
        apb(1'b1, PMS_OFF_CTRL, 32'h3);
        repeat (20) @(posedge pclk);
        apb(1'b1, PMS_OFF_CRC, 32'h1);
        apb_rd(PMS_OFF_CTRL, 32'h5);
        apb_rd(PMS_OFF_STATUS, 32'h1);
        apb(1'b1, PMS_OFF_STATUS, 32'h1);
        apb(1'b1, PMS_OFF_MASK, 32'h0);
        apb(1'b1, PMS_OFF_CRC, 32'h3);
        apb(1'b1, PMS_OFF_CTRL, 32'h3);
        repeat (20) @(posedge pclk);
        apb(1'b1, PMS_OFF_CTRL, 32'h1);
        apb_rd(PMS_OFF_CTRL, 32'h1);
        c_snap = word_count;
        repeat (20) @(posedge pclk);
        check(32'(word_count), 32'(c_snap));
        apb_rd(PMS_OFF_STATUS, 32'h1);
        check(32'(irq), 32'h0);
        apb(1'b1, PMS_OFF_MASK, 32'h1);
        apb_rd(PMS_OFF_MASK, 32'h1);
        check(32'(irq), 32'h1);
        apb(1'b1, PMS_OFF_CTRL, 32'h0);
        apb_rd(PMS_OFF_START, 32'h10);
        check(32'(crc_reset), 32'h1);
        end_sim();
    end
endmodule

bind pmscan pmscan_properties i_pmscan_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nvm_req(nvm_req), .crc_ready(crc_ready), .crc_data_valid(crc_data_valid),
    .irq(irq));

/* verilog/pmscan.sv */
/*
 Program-memory scanner: walks flash from a start to an end address and hands
 each word to a CRC engine, in burst, concurrent, triggered or peek mode.
 Assumes: one clock pclk (instruction clock), APB slave for registers, flash
 answers a read in the cycle after the request, CRC engine logic outside.
*/
// Decided for this implementation: the APB interface to the registers and the address map.
// Operation
// - Both enables needed; clearing either resets scanner state, keeps registers.
// - Start and end addresses come from two software-written address registers.
// - Losing CRC enable or CRC run mid-scan aborts and sets invalid.
// - Wait for CRC ready before the first location is fed.
// - Stop at end or unimplemented address, clear run, raise completion.
// - Software may clear scanner run to stop the scan early.
// - Interrupt is raised whenever scanner run falls from one to zero.
// - Done flag sets once the last word is written into the CRC input.
// - Only software clears the done flag; a mask enable gates it.
// - Mode field: 01 burst, 00 concurrent, 11 triggered, 10 peek.
// - Burst mode stalls the processor from the next operation until scan stops.
// - In burst mode the stall lasts until a hardware end condition.
// - Concurrent mode stalls the processor only during each memory access.
// - Triggered mode waits for a rising trigger edge, source chosen by select.
// - Peek mode accesses memory only in cycles the processor leaves free.
`timescale 1ns/1ps
module pmscan
    import pmscan_pkg::*;
#(
    parameter int AW        = 22,
    parameter int DW        = 16,
    parameter int NTRIG     = 8,
    parameter int TSEL_W    = 3
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic [AW-1:0]          nvm_addr,
    output logic                   nvm_req,
    input  wire logic [DW-1:0]     nvm_rdata,
    input  wire logic              nvm_unimpl,
    input  wire logic              cpu_nvm_busy,
    output logic                   cpu_stall,
    input  wire logic              crc_ready,
    output logic [DW-1:0]          crc_data,
    output logic                   crc_data_valid,
    output logic                   crc_reset,
    input  wire logic [NTRIG-1:0]  trig_in,
    output logic                   irq
);

    // Refuse sizes the address walker and register read-back cannot serve
    if (AW < 1 || AW > 32 || DW < 1 || DW > 32 || NTRIG < 1 || NTRIG > (1 << TSEL_W)) begin : g_param_check
        $error("pmscan: unsupported parameter values");
    end

    // Software-visible registers
    logic              scan_en_q;
    logic              scan_run_q;
    logic              invalid_q;
    logic [1:0]        mode_q;
    logic [1:0]        irqm_q;
    logic [AW-1:0]     start_q;
    logic [AW-1:0]     end_q;
    logic [TSEL_W-1:0] tsel_q;
    logic              crc_en_q;
    logic              crc_run_q;
    logic              done_q;
    logic              mask_q;

    // Internal scan state
    pms_state_t        state_q;
    pms_state_t        state_d;
    logic [AW-1:0]     cur_q;
    logic              rd_pend_q;
    logic              trig_q;
    logic              burst_hold_q;

    // APB decode
    wire apb_acc   = psel && penable;
    wire apb_wr    = apb_acc && pwrite;
    wire wr_ctrl   = apb_wr && (paddr == PMS_OFF_CTRL);
    wire wr_start  = apb_wr && (paddr == PMS_OFF_START);
    wire wr_end    = apb_wr && (paddr == PMS_OFF_END);
    wire wr_trig   = apb_wr && (paddr == PMS_OFF_TRIG);
    wire wr_crc    = apb_wr && (paddr == PMS_OFF_CRC);
    wire wr_status = apb_wr && (paddr == PMS_OFF_STATUS);
    wire wr_mask   = apb_wr && (paddr == PMS_OFF_MASK);
    wire addr_ok   = (paddr == PMS_OFF_CTRL) || (paddr == PMS_OFF_START) || (paddr == PMS_OFF_END)
                   || (paddr == PMS_OFF_TRIG) || (paddr == PMS_OFF_CRC) || (paddr == PMS_OFF_STATUS)
                   || (paddr == PMS_OFF_MASK) || (paddr == PMS_OFF_CURADDR);

    // Operating conditions
    wire crc_ok     = crc_en_q && crc_run_q;
    wire active     = (state_q != PMS_IDLE);
    wire both_en    = scan_en_q && crc_en_q;
    wire abort      = active && !crc_ok;
    wire last_loc   = (cur_q == end_q) || nvm_unimpl;
    wire trig_sel   = trig_in[tsel_q];
    wire trig_rise  = trig_sel && !trig_q;
    wire peek_ok    = (mode_q != PMS_MODE_PEEK) || !cpu_nvm_busy;
    wire deliver    = (state_q == PMS_DELIVER) && crc_ready;
    wire finish     = deliver && last_loc;
    // Software may stop a scan, except in burst mode where the processor is held
    wire sw_stop    = wr_ctrl && !pwdata[PMS_CTRL_RUN] && !burst_hold_q;
    wire sw_go      = wr_ctrl && pwdata[PMS_CTRL_RUN] && !scan_run_q;
    wire run_fall   = scan_run_q && (finish || abort || sw_stop || !both_en);

    // Next scan state
    always_comb begin
        state_d = state_q;
        case (state_q)
            PMS_IDLE: begin
                if (sw_go && both_en && crc_ok) begin
                    state_d = (mode_q == PMS_MODE_TRIG) ? PMS_WAIT_TRIG : PMS_WAIT_CRC;
                end
            end
            PMS_WAIT_TRIG: begin
                if (trig_rise) begin
                    state_d = PMS_WAIT_CRC;
                end
            end
            PMS_WAIT_CRC: begin
                if (crc_ready && peek_ok) begin
                    state_d = PMS_READ;
                end
            end
            PMS_READ: begin
                state_d = PMS_DELIVER;
            end
            PMS_DELIVER: begin
                if (finish) begin
                    state_d = PMS_IDLE;
                end else if (crc_ready) begin
                    state_d = PMS_WAIT_CRC;
                end
            end
            default: begin
                state_d = PMS_IDLE;
            end
        endcase
        if (abort || !both_en || sw_stop) begin
            state_d = PMS_IDLE;
        end
    end

    // Scan state and address walker; rd_pend_q marks the cycle the flash answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= PMS_IDLE;
            cur_q     <= '0;
            rd_pend_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            rd_pend_q <= (state_q == PMS_READ);
            if (state_q == PMS_IDLE && state_d != PMS_IDLE) begin
                cur_q <= start_q;
            end else if (deliver) begin
                cur_q <= cur_q + AW'(1);
            end
        end
    end

    // Trigger edge history; cleared when disabled, yet a level already high when a scan starts does not count as an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= both_en ? trig_sel : 1'b0;
        end
    end

    // Scanner control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_en_q  <= 1'b0;
            scan_run_q <= 1'b0;
            invalid_q  <= 1'b0;
            mode_q     <= PMS_MODE_RST;
            irqm_q     <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                scan_en_q <= pwdata[PMS_CTRL_EN];
                mode_q    <= pwdata[PMS_CTRL_MODE_LO +: 2];
                irqm_q    <= pwdata[PMS_CTRL_IRQM_LO +: 2];
                invalid_q <= pwdata[PMS_CTRL_INVALID];
            end
            if (abort) begin
                invalid_q <= 1'b1;
            end
            if (sw_go && both_en && crc_ok) begin
                scan_run_q <= 1'b1;
            end else if (run_fall) begin
                scan_run_q <= 1'b0;
            end
        end
    end

    // Address, trigger-select and CRC control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q   <= '0;
            end_q     <= '0;
            tsel_q    <= PMS_TRIG_RST;
            crc_en_q  <= 1'b0;
            crc_run_q <= 1'b0;
        end else begin
            if (wr_start) start_q <= pwdata[AW-1:0];
            if (wr_end)   end_q   <= pwdata[AW-1:0];
            if (wr_trig)  tsel_q  <= pwdata[TSEL_W-1:0];
            if (wr_crc) begin
                crc_en_q  <= pwdata[PMS_CRC_EN];
                crc_run_q <= pwdata[PMS_CRC_RUN];
            end
        end
    end

    // Done flag: set wins over a software clear; hardware never clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (finish || run_fall) begin
                done_q <= 1'b1;
            end else if (wr_status && pwdata[PMS_ST_DONE]) begin
                done_q <= 1'b0;
            end
            if (wr_mask) mask_q <= pwdata[PMS_ST_DONE];
        end
    end

    // Burst hold: CPU held from the operation after the start until the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_hold_q <= 1'b0;
        end else begin
            burst_hold_q <= (state_d != PMS_IDLE) && (mode_q == PMS_MODE_BURST);
        end
    end

    // Memory and CRC side outputs, all registered
    wire stall_d = ((state_d != PMS_IDLE) && (mode_q == PMS_MODE_BURST))
                 || ((state_d == PMS_READ) && (mode_q != PMS_MODE_PEEK));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_addr       <= '0;
            nvm_req        <= 1'b0;
            cpu_stall      <= 1'b0;
            crc_data       <= '0;
            crc_data_valid <= 1'b0;
            crc_reset      <= 1'b1;
            irq            <= 1'b0;
        end else begin
            nvm_req        <= (state_q == PMS_WAIT_CRC) && (state_d == PMS_READ);
            nvm_addr       <= cur_q;
            cpu_stall      <= stall_d;
            crc_reset      <= !both_en;
            crc_data_valid <= deliver;
            // Flash data stands only in the cycle after the request
            if (rd_pend_q) begin
                crc_data <= nvm_rdata;
            end
            irq            <= done_q && mask_q;
        end
    end

    // APB read side; one wait-free access phase, unmapped offsets flag an error
    wire [31:0] ctrl_rd = {24'h0, irqm_q, mode_q, active, invalid_q, scan_run_q, scan_en_q};
    wire [31:0] rd_mux  = (paddr == PMS_OFF_CTRL)    ? ctrl_rd
                        : (paddr == PMS_OFF_START)   ? 32'(start_q)
                        : (paddr == PMS_OFF_END)     ? 32'(end_q)
                        : (paddr == PMS_OFF_TRIG)    ? 32'(tsel_q)
                        : (paddr == PMS_OFF_CRC)     ? {30'h0, crc_run_q, crc_en_q}
                        : (paddr == PMS_OFF_STATUS)  ? {31'h0, done_q}
                        : (paddr == PMS_OFF_MASK)    ? {31'h0, mask_q}
                        : (paddr == PMS_OFF_CURADDR) ? 32'(cur_q)
                        : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

endmodule

/* verilog/pmscan_pkg.sv */
/*
 Package for the program-memory scanner: register offsets, field positions,
 reset values and mode encodings shared by the scanner design.
 Assumes a 32-bit APB register bus with one register per aligned word.
*/
package pmscan_pkg;
    // Register byte offsets
    localparam logic [7:0] PMS_OFF_CTRL    = 8'h00;
    localparam logic [7:0] PMS_OFF_START   = 8'h04;
    localparam logic [7:0] PMS_OFF_END     = 8'h08;
    localparam logic [7:0] PMS_OFF_TRIG    = 8'h0c;
    localparam logic [7:0] PMS_OFF_CRC     = 8'h10;
    localparam logic [7:0] PMS_OFF_STATUS  = 8'h14;
    localparam logic [7:0] PMS_OFF_MASK    = 8'h18;
    localparam logic [7:0] PMS_OFF_CURADDR = 8'h1c;

    // Scanner control field positions
    localparam int PMS_CTRL_EN      = 0;
    localparam int PMS_CTRL_RUN     = 1;
    localparam int PMS_CTRL_INVALID = 2;
    localparam int PMS_CTRL_BUSY    = 3;
    localparam int PMS_CTRL_MODE_LO = 4;
    localparam int PMS_CTRL_IRQM_LO = 6;

    // CRC control field positions
    localparam int PMS_CRC_EN  = 0;
    localparam int PMS_CRC_RUN = 1;

    // Status and mask bit positions
    localparam int PMS_ST_DONE = 0;

    // Reset values
    localparam logic [1:0] PMS_MODE_RST = 2'h0;
    localparam logic [2:0] PMS_TRIG_RST = 3'h0;

    // Access mode encodings
    localparam logic [1:0] PMS_MODE_CONC  = 2'h0;
    localparam logic [1:0] PMS_MODE_BURST = 2'h1;
    localparam logic [1:0] PMS_MODE_PEEK  = 2'h2;
    localparam logic [1:0] PMS_MODE_TRIG  = 2'h3;

    typedef enum logic [2:0] {
        PMS_IDLE,
        PMS_WAIT_TRIG,
        PMS_WAIT_CRC,
        PMS_READ,
        PMS_DELIVER
    } pms_state_t;
endpackage
